// >>> adcsq_sequencer.sv
// Summary of operation
// - Done flag sets at conversion end, clears on reading high result byte.
// - Software start bit starts only with source 11 and idle; clears at end.
// - Four start sources: pin rising edge, previous end, timer compare, software bit.
// - Start source codes 00 pin, 01 free run, 10 timer, 11 software; reset 11.
// - Decimation codes give rates 64, 128, 256, 512 with 7, 9, 10, 12 bits.
// - Codes below 1000 walk inputs from 0; 1000-1011 walk pairs; higher single.
// - Extra register write queues one conversion after sequence, else immediately.
// - Extra register picks input, reference, decimation with sequence encodings.
// - Channel readback and done flag update even with no analog pins.
// - Reference choice among four sources; reference and ground usable as inputs.
// - Results two's complement, single-ended 0..2047, differential -2048..2047.
// - Result left-justified in high and low bytes; low byte bits 7:4.
// - Completion in the same cycle as a high result byte read keeps the done flag set.
// - Channel readback shows last conversion; sequence codes below 1100 read plus one.
// - After extra conversion the channel readback equals the written extra code.
// - Converter clock is system clock divided by six.
// - Conversion lasts decimation rate plus 16 converter clock periods.
// - Interrupt request only on extra conversion completion.
// - Per-channel DMA trigger pulses for each sequence or single sample.
// - All-channel DMA trigger on sequence or single data, never for extra.
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
module adcsq_sequencer (
    input  wire logic                       mclk,
    input  wire logic                       rst,
    input  wire adcsq_pkg::adcsq_bus_req_type bus_req,
    output logic [7:0]                      bus_rdata,
    input  wire logic                       external_trigger_pin,
    input  wire logic                       timer_compare_event,
    input  wire logic                       modulator_bit,
    output adcsq_pkg::adcsq_cfg_type        mux_cfg,
    output logic                            converting,
    output logic                            irq_extra,
    output logic [8:0]                      dma_channel_trigger,
    output logic                            all_channels_dma_trigger
);

    // ----------------------------------------
    // Block state
    // ----------------------------------------
    typedef struct packed {
        adcsq_pkg::adcsq_state_type fsm;
        logic                       eoc;
        logic                       st;
        logic [1:0]                 start_source_select;
        logic [3:0]                 ctrl_low;

        adcsq_pkg::adcsq_cfg_type   seq_cfg;
        logic [3:0]                 sch_rb;
        adcsq_pkg::adcsq_cfg_type   extra_cfg;
        logic                       extra_pend;

        adcsq_pkg::adcsq_cfg_type   mux;
        logic [11:0]                result;
        logic [7:0]                 rdata;

        logic                       pin_s1;
        logic                       pin_s2;
        logic                       pin_s3;
        logic                       mod_s1;
        logic                       mod_s2;

        logic                       dec_start;
        logic                       busy;
        logic                       irq;
        logic [8:0]                 dma;
        logic                       dma_all;
    } adcsq_main_state_type;

    adcsq_main_state_type s_q;
    adcsq_main_state_type s_d;

    logic                 adc_tick;
    logic                 dec_done;
    logic [11:0]          dec_result;

    // ----------------------------------------
    // Converter clock and decimation filter
    // ----------------------------------------
    adcsq_clk_div u_clk_div (
        .mclk     (mclk),
        .rst      (rst),
        .adc_tick (adc_tick)
    );

    adcsq_decimator u_decimator (
        .mclk              (mclk),
        .rst               (rst),
        .adc_tick          (adc_tick),
        .start             (s_q.dec_start),
        .decimation_select (s_q.mux.decimation_select),
        .modulator_bit     (s_q.mod_s2),
        .done              (dec_done),
        .result            (dec_result)
    );

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always_comb begin
        logic       wr_ctrl;
        logic       wr_extra;
        logic       start_ok;
        logic [3:0] first;
        logic [3:0] nxt;
        wr_ctrl = bus_req.wr && (bus_req.addr == adcsq_pkg::CTRL_ADDR);
        wr_extra = bus_req.wr && (bus_req.addr == adcsq_pkg::EXTRA_ADDR);
        start_ok = 1'b0;
        first = adcsq_pkg::CH_SE_FIRST;
        nxt = s_q.mux.chan + adcsq_pkg::CH_STEP;

        s_d = s_q;
        s_d.dec_start = 1'b0;
        s_d.irq = 1'b0;
        s_d.dma = '0;
        s_d.dma_all = 1'b0;
        s_d.rdata = adcsq_pkg::READ_ZERO;

        // Pin and bit-stream synchronisers
        s_d.pin_s1 = external_trigger_pin;
        s_d.pin_s2 = s_q.pin_s1;
        s_d.pin_s3 = s_q.pin_s2;

        s_d.mod_s1 = modulator_bit;
        s_d.mod_s2 = s_q.mod_s1;

        // Register reads, data in the next cycle
        if (bus_req.rd) begin
            case (bus_req.addr)
                adcsq_pkg::CTRL_ADDR: begin
                    s_d.rdata = {s_q.eoc, s_q.st, s_q.start_source_select, s_q.ctrl_low};
                end

                adcsq_pkg::SEQ_ADDR: begin
                    s_d.rdata = {s_q.seq_cfg.reference_select, s_q.seq_cfg.decimation_select, s_q.sch_rb};
                end

                adcsq_pkg::EXTRA_ADDR: begin
                    s_d.rdata = s_q.extra_cfg;
                end

                adcsq_pkg::RES_LO_ADDR: begin
                    s_d.rdata = {s_q.result[3:0], 4'h0};
                end

                adcsq_pkg::RES_HI_ADDR: begin
                    s_d.rdata = s_q.result[11:4];
                    s_d.eoc = 1'b0;
                end

                default: begin
                    s_d.rdata = adcsq_pkg::READ_ZERO;
                end
            endcase
        end

        // Register writes
        if (bus_req.wr) begin
            case (bus_req.addr)
                adcsq_pkg::CTRL_ADDR: begin
                    // Start bit is write-one only
                    if (bus_req.wdata[adcsq_pkg::ST_BIT]) begin
                        s_d.st = 1'b1;
                    end
                    s_d.start_source_select = bus_req.wdata[adcsq_pkg::START_SOURCE_SELECT_MSB:adcsq_pkg::START_SOURCE_SELECT_LSB];
                    s_d.ctrl_low = bus_req.wdata[3:0];
                end

                adcsq_pkg::SEQ_ADDR: begin
                    s_d.seq_cfg = bus_req.wdata;
                    s_d.sch_rb = bus_req.wdata[3:0];
                end

                adcsq_pkg::EXTRA_ADDR: begin
                    s_d.extra_cfg = bus_req.wdata;
                    s_d.extra_pend = 1'b1;
                end

                default: begin
                end
            endcase
        end

        // Start source selection
        case (s_q.start_source_select)
            adcsq_pkg::SRC_PIN: begin
                start_ok = s_q.pin_s2 && !s_q.pin_s3;
            end
            adcsq_pkg::SRC_FREE: begin
                start_ok = 1'b1;
            end
            adcsq_pkg::SRC_TIMER: begin
                start_ok = timer_compare_event;
            end
            adcsq_pkg::SRC_SOFT: begin
                start_ok = s_q.st;
            end
            default: begin
                start_ok = 1'b0;
            end
        endcase

        // First code of a sequence
        if (s_q.seq_cfg.chan < adcsq_pkg::CH_DIFF_FIRST) begin
            first = adcsq_pkg::CH_SE_FIRST;
        end else if (s_q.seq_cfg.chan < adcsq_pkg::CH_FIXED_FIRST) begin
            first = adcsq_pkg::CH_DIFF_FIRST;
        end else begin
            first = s_q.seq_cfg.chan;
        end

        // Conversion control
        case (s_q.fsm)
            // Queued extra goes first
            adcsq_pkg::ADCSQ_IDLE: begin
                if (s_q.extra_pend) begin
                    s_d.fsm = adcsq_pkg::ADCSQ_EXTRA;
                    s_d.busy = 1'b1;
                    s_d.dec_start = 1'b1;
                    s_d.mux = s_q.extra_cfg;
                    s_d.extra_pend = wr_extra;
                end else if (start_ok) begin
                    s_d.fsm = adcsq_pkg::ADCSQ_SEQ;
                    s_d.busy = 1'b1;
                    s_d.dec_start = 1'b1;
                    s_d.mux = {s_q.seq_cfg.reference_select, s_q.seq_cfg.decimation_select, first};
                end
            end

            // Store, then step or end
            adcsq_pkg::ADCSQ_SEQ: begin
                if (dec_done) begin
                    s_d.result = dec_result;
                    s_d.eoc = 1'b1;
                    s_d.sch_rb = (s_q.mux.chan < adcsq_pkg::CH_FIXED_FIRST) ? nxt : s_q.mux.chan;

                    if (s_q.mux.chan < adcsq_pkg::CH_DIFF_FIRST) begin
                        s_d.dma[s_q.mux.chan[2:0]] = 1'b1;
                    end else begin
                        s_d.dma[adcsq_pkg::DMA_SINGLE_IDX] = 1'b1;
                    end
                    s_d.dma_all = 1'b1;

                    // Last code ends the walk
                    if (s_q.mux.chan == s_q.seq_cfg.chan || s_q.mux.chan >= adcsq_pkg::CH_FIXED_FIRST) begin
                        s_d.fsm = adcsq_pkg::ADCSQ_IDLE;
                        s_d.busy = 1'b0;
                        s_d.st = wr_ctrl && bus_req.wdata[adcsq_pkg::ST_BIT];
                    end else begin
                        s_d.mux.chan = nxt;
                        s_d.dec_start = 1'b1;
                    end
                end
            end

            // Extra: interrupt, no DMA
            adcsq_pkg::ADCSQ_EXTRA: begin
                if (dec_done) begin
                    s_d.result = dec_result;
                    s_d.eoc = 1'b1;
                    s_d.sch_rb = s_q.mux.chan;
                    s_d.irq = 1'b1;
                    s_d.fsm = adcsq_pkg::ADCSQ_IDLE;
                    s_d.busy = 1'b0;
                end
            end

            // Illegal code to idle
            default: begin
                s_d.fsm = adcsq_pkg::ADCSQ_IDLE;
                s_d.busy = 1'b0;
            end
        endcase
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            s_q <= '0;
            // Fields with named reset values
            s_q.fsm <= adcsq_pkg::ADCSQ_IDLE;
            s_q.start_source_select <= adcsq_pkg::START_SOURCE_SELECT_RST;
            s_q.ctrl_low <= adcsq_pkg::CTRL_LOW_RST;
            s_q.seq_cfg <= adcsq_pkg::SEQ_RST;
            s_q.extra_cfg <= adcsq_pkg::EXTRA_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign bus_rdata = s_q.rdata;
    assign mux_cfg = s_q.mux;
    assign converting = s_q.busy;
    assign irq_extra = s_q.irq;
    assign dma_channel_trigger = s_q.dma;
    assign all_channels_dma_trigger = s_q.dma_all;

endmodule // adcsq_sequencer

// >>> adcsq_pkg.sv
package adcsq_pkg;

    // ----------------------------------------
    // Register map and reset values
    // ----------------------------------------
    localparam logic [7:0] CTRL_ADDR    = 8'hB4;
    localparam logic [7:0] SEQ_ADDR     = 8'hB5;
    localparam logic [7:0] EXTRA_ADDR   = 8'hB6;
    localparam logic [7:0] RES_LO_ADDR  = 8'hBA;
    localparam logic [7:0] RES_HI_ADDR  = 8'hBB;
    localparam logic [1:0] START_SOURCE_SELECT_RST    = 2'h3;
    localparam logic [3:0] CTRL_LOW_RST = 4'h3;
    localparam logic [7:0] SEQ_RST      = 8'h10;
    localparam logic [7:0] EXTRA_RST    = 8'h00;
    localparam logic [7:0] READ_ZERO    = 8'h00;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int EOC_BIT   = 7;
    localparam int ST_BIT    = 6;
    localparam int START_SOURCE_SELECT_MSB = 5;
    localparam int START_SOURCE_SELECT_LSB = 4;

    // ----------------------------------------
    // Start sources and channel codes
    // ----------------------------------------
    localparam logic [1:0] SRC_PIN   = 2'h0;
    localparam logic [1:0] SRC_FREE  = 2'h1;
    localparam logic [1:0] SRC_TIMER = 2'h2;
    localparam logic [1:0] SRC_SOFT  = 2'h3;
    localparam logic [3:0] CH_DIFF_FIRST  = 4'h8;
    localparam logic [3:0] CH_FIXED_FIRST = 4'hC;
    localparam logic [3:0] CH_SE_FIRST    = 4'h0;
    localparam logic [3:0] CH_STEP        = 4'h1;

    // ----------------------------------------
    // Timing and decimation
    // ----------------------------------------
    localparam logic [2:0] ADC_DIV_LAST = 3'h5;
    localparam logic [9:0] SETTLE_CYCLES = 10'h010;
    localparam logic [3:0][9:0] DEC_RATE = {10'h200, 10'h100, 10'h080, 10'h040};
    localparam logic [3:0][3:0] DEC_SHIFT = {4'h2, 4'h3, 4'h4, 4'h5};
    localparam logic [3:0][11:0] RES_MASK = {12'hFFF, 12'hFFC, 12'hFF8, 12'hFE0};
    localparam logic signed [15:0] CLIP_HI = 16'sh07FF;
    localparam logic signed [15:0] CLIP_LO = 16'shF800;

    // ----------------------------------------
    // DMA triggers
    // ----------------------------------------
    localparam int DMA_TRIG_N     = 9;
    localparam int DMA_SINGLE_IDX = 8;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {
        ADCSQ_IDLE  = 2'b00,
        ADCSQ_SEQ   = 2'b01,
        ADCSQ_EXTRA = 2'b10
    } adcsq_state_type;

    typedef struct packed {
        logic [1:0] reference_select;
        logic [1:0] decimation_select;
        logic [3:0] chan;
    } adcsq_cfg_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } adcsq_bus_req_type;

    typedef struct packed {
        logic [2:0] cnt;
        logic       tick;
    } adcsq_div_state_type;

    typedef struct packed {
        logic               busy;
        logic [1:0]         div;
        logic [9:0]         cnt;
        logic signed [10:0] acc;
        logic               done;
        logic [11:0]        result;
    } adcsq_dec_state_type;

endpackage

// >>> adcsq_clk_div.sv
`timescale 1ns/1ps
module adcsq_clk_div (
    input  wire logic mclk,
    input  wire logic rst,
    output logic      adc_tick
);

    adcsq_pkg::adcsq_div_state_type s_q;
    adcsq_pkg::adcsq_div_state_type s_d;

    // Divide by six: one tick per ADC clock period
    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (s_q.cnt == adcsq_pkg::ADC_DIV_LAST) begin
            s_d.cnt = 3'h0;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + 3'h1;
        end
    end

    // State register
    always_ff @(posedge mclk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign adc_tick = s_q.tick;

endmodule // adcsq_clk_div

// >>> adcsq_decimator.sv
`timescale 1ns/1ps
module adcsq_decimator (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        adc_tick,
    input  wire logic        start,
    input  wire logic [1:0]  decimation_select,
    input  wire logic        modulator_bit,
    output logic             done,
    output logic [11:0]      result
);

    adcsq_pkg::adcsq_dec_state_type s_q;
    adcsq_pkg::adcsq_dec_state_type s_d;

    // Settle, integrate the bit stream, scale and justify
    always_comb begin
        logic signed [10:0] acc_n;
        logic signed [15:0] wide;
        logic [9:0]         last;
        logic [11:0]        clipped;
        acc_n = s_q.acc;
        wide = 16'sh0000;
        clipped = 12'h000;
        last = adcsq_pkg::SETTLE_CYCLES + adcsq_pkg::DEC_RATE[s_q.div] - 10'h001;
        s_d = s_q;
        s_d.done = 1'b0;
        if (start) begin
            s_d.busy = 1'b1;
            s_d.div = decimation_select;
            s_d.cnt = 10'h000;
            s_d.acc = 11'sh000;
        end else if (s_q.busy && adc_tick) begin
            // Multiplexer settling periods are not integrated
            if (s_q.cnt >= adcsq_pkg::SETTLE_CYCLES) begin
                acc_n = modulator_bit ? s_q.acc + 11'sh001 : s_q.acc - 11'sh001;
            end
            s_d.acc = acc_n;
            s_d.cnt = s_q.cnt + 10'h001;
            if (s_q.cnt == last) begin
                wide = {{5{acc_n[10]}}, acc_n} <<< adcsq_pkg::DEC_SHIFT[s_q.div];
                if (wide > adcsq_pkg::CLIP_HI) begin
                    clipped = 12'h7FF;
                end else if (wide < adcsq_pkg::CLIP_LO) begin
                    clipped = 12'h800;
                end else begin
                    clipped = wide[11:0];
                end
                s_d.result = clipped & adcsq_pkg::RES_MASK[s_q.div];
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge mclk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign done = s_q.done;
    assign result = s_q.result;

endmodule // adcsq_decimator

// >>> adcsq_sequencer_checker.sv
`timescale 1ns/1ps
module adcsq_sequencer_checker (
    input wire logic                         mclk,
    input wire logic                         rst,
    input wire adcsq_pkg::adcsq_bus_req_type bus_req,
    input wire logic [7:0]                   bus_rdata,
    input wire logic                         external_trigger_pin,
    input wire logic                         timer_compare_event,
    input wire logic                         modulator_bit,
    input wire adcsq_pkg::adcsq_cfg_type     mux_cfg,
    input wire logic                         converting,
    input wire logic                         irq_extra,
    input wire logic [8:0]                   dma_channel_trigger,
    input wire logic                         all_channels_dma_trigger
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    // ----
    // Cycles since start or last sample
    // ----
    logic [11:0] gap_q;
    logic        conv_q;
    logic        fin;
    assign fin = all_channels_dma_trigger | irq_extra;
    // Saturating gap counter
    always_ff @(posedge mclk) begin
        conv_q <= converting;
        if (rst || fin || (converting && !conv_q)) begin
            gap_q <= 12'h000;
        end else if (gap_q != 12'hFFF) begin
            gap_q <= gap_q + 12'h001;
        end
    end

    // ----
    // Properties
    // ----
    property p_irq_no_dma;
        irq_extra |-> !all_channels_dma_trigger && dma_channel_trigger == 9'h000;
    endproperty
    a_irq_no_dma: assert property (p_irq_no_dma)
        else $error("dma trigger beside extra done");
    property p_dma_onehot;
        |dma_channel_trigger |-> $onehot(dma_channel_trigger) && all_channels_dma_trigger;
    endproperty
    a_dma_onehot: assert property (p_dma_onehot)
        else $error("channel trigger not one-hot or alone");
    property p_all_has_ch;
        all_channels_dma_trigger |-> |dma_channel_trigger;
    endproperty
    a_all_has_ch: assert property (p_all_has_ch)
        else $error("all-channel trigger without channel trigger");
    property p_fin_in_conv;
        fin |-> $past(converting);
    endproperty
    a_fin_in_conv: assert property (p_fin_in_conv)
        else $error("sample ready while idle");
    property p_irq_pulse;
        irq_extra |=> !irq_extra;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse)
        else $error("interrupt longer than one cycle");
    property p_min_time;
        fin |-> gap_q >= 12'h1DA;
    endproperty
    a_min_time: assert property (p_min_time)
        else $error("conversion shorter than rate plus settling");
    property p_max_time;
        converting |-> gap_q <= 12'hC80;
    endproperty
    a_max_time: assert property (p_max_time)
        else $error("conversion longer than largest rate");
    property p_read_clears;
        (bus_req.rd && bus_req.addr == 8'hBB && !fin) ##1 !fin
            ##1 (bus_req.rd && bus_req.addr == 8'hB4 && !fin) |=> !bus_rdata[7];
    endproperty
    a_read_clears: assert property (p_read_clears)
        else $error("done flag survives high byte read");

    // Main scenarios
    c_extra: cover property (irq_extra);
    c_pair: cover property (dma_channel_trigger[8]);
    c_start: cover property ($rose(converting));
endmodule // adcsq_sequencer_checker

bind adcsq_sequencer adcsq_sequencer_checker chk_u (
    .mclk(mclk), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .external_trigger_pin(external_trigger_pin), .timer_compare_event(timer_compare_event),
    .modulator_bit(modulator_bit), .mux_cfg(mux_cfg), .converting(converting), .irq_extra(irq_extra),
    .dma_channel_trigger(dma_channel_trigger), .all_channels_dma_trigger(all_channels_dma_trigger)
);

// >>> adcsq_far_model.sv
`timescale 1ns/1ps
module adcsq_far_model (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       clr,
    input  wire logic       mod_level,
    input  wire logic [8:0] dma_channel_trigger,
    input  wire logic       all_channels_dma_trigger,
    input  wire logic       irq_extra,
    output logic            modulator_bit,
    output logic [8:0][7:0] ch_cnt,
    output logic [7:0]      all_cnt,
    output logic [7:0]      irq_cnt
);
    // Modulator held at full scale either way
    assign modulator_bit = mod_level;
    // DMA controller and CPU: count requests
    always_ff @(posedge mclk) begin
        if (rst || clr) begin
            ch_cnt <= '0;
            all_cnt <= 8'h00;
            irq_cnt <= 8'h00;
        end else begin
            for (int i = 0; i < 9; i++) begin
                ch_cnt[i] <= ch_cnt[i] + {7'h00, dma_channel_trigger[i]};
            end
            all_cnt <= all_cnt + {7'h00, all_channels_dma_trigger};
            irq_cnt <= irq_cnt + {7'h00, irq_extra};
        end
    end
endmodule // adcsq_far_model

// >>> test_adc_sequencer_control.sv
`timescale 1ns/1ps
module test_adc_sequencer_control;
    logic                         mclk, rst, ext_pin, tmr_evt, mod_level, clr, mod_bit, conv, irq, all_trig;
    adcsq_pkg::adcsq_bus_req_type bus_req;
    adcsq_pkg::adcsq_cfg_type     mux_cfg;
    logic [7:0]                   rdata, all_cnt, irq_cnt;
    logic [8:0]                   dma;
    logic [8:0][7:0]              ch_cnt;
    int                           err_total, n_compared;
    logic [7:0]                   rst_a [6] = '{8'hB4, 8'hB5, 8'hB6, 8'hBA, 8'hBB, 8'hC0};
    logic [7:0]                   rst_v [6] = '{8'h33, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00};

    // Clock, undivided
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    adcsq_sequencer dut_u (
        .mclk(mclk), .rst(rst), .bus_req(bus_req), .bus_rdata(rdata), .external_trigger_pin(ext_pin),
        .timer_compare_event(tmr_evt), .modulator_bit(mod_bit), .mux_cfg(mux_cfg), .converting(conv),
        .irq_extra(irq), .dma_channel_trigger(dma), .all_channels_dma_trigger(all_trig)
    );
    adcsq_far_model far_u (
        .mclk(mclk), .rst(rst), .clr(clr), .mod_level(mod_level), .dma_channel_trigger(dma),
        .all_channels_dma_trigger(all_trig), .irq_extra(irq), .modulator_bit(mod_bit),
        .ch_cnt(ch_cnt), .all_cnt(all_cnt), .irq_cnt(irq_cnt)
    );

    // ----
    // Tasks
    // ----
    task automatic stop_test();
        $display("Compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One bus access; read data sampled in the cycle after the strobe
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
        bus_req <= '{addr: a, wdata: d, wr: w, rd: !w};
        @(posedge mclk);
        bus_req <= '0;
        @(negedge mclk);
        r = rdata;
        @(posedge mclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        acc(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] r;
        acc(1'b0, a, 8'h00, r);
        cmp($sformatf("reg %h", a), exp, r);
    endtask
    task automatic clr_cnt();
        clr <= 1'b1;
        @(posedge mclk);
        clr <= 1'b0;
    endtask
    // Bounded wait: 0 busy level, 1 interrupt count, 2 sample count
    task automatic wait_until(input int sel, input logic [7:0] v, input int lim);
        logic [7:0] cur;
        int         i;
        i = 0;
        do begin
            @(negedge mclk);
            i++;
            cur = (sel == 0) ? {7'h00, conv} : (sel == 1) ? irq_cnt : all_cnt;
        end while (cur !== v && i < lim);
        cmp($sformatf("wait %0d", sel), v, cur);
        @(negedge mclk);
        @(posedge mclk);
    endtask

    // Watchdog
    initial begin
        #600000;
        err_total++;
        stop_test();
    end

    // ----
    // Scenarios
    // ----
    initial begin
        bus_req = '0;
        rst = 1'b1;
        ext_pin = 1'b0;
        tmr_evt = 1'b0;
        mod_level = 1'b1;
        clr = 1'b0;
        err_total = 0;
        n_compared = 0;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        for (int i = 0; i < 6; i++) begin
            rd(rst_a[i], rst_v[i]);
        end
        // Software start, inputs 0 to 2
        wr(8'hB5, 8'h02);
        clr_cnt();
        wr(8'hB4, 8'h73);
        wait_until(0, 8'h01, 10);
        wait_until(0, 8'h00, 3000);
        for (int i = 0; i < 4; i++) begin
            cmp($sformatf("dma %0d", i), (i < 3) ? 8'h01 : 8'h00, ch_cnt[i]);
        end
        cmp("all", 8'h03, all_cnt);
        cmp("irq", 8'h00, irq_cnt);
        rd(8'hB4, 8'hB3);
        rd(8'hB5, 8'h03);
        rd(8'hBA, 8'h00);
        rd(8'hBB, 8'h7E);
        rd(8'hB4, 8'h33);
        // Pin source: start bit alone must not start
        wr(8'hB5, 8'h0C);
        clr_cnt();
        wr(8'hB4, 8'h43);
        repeat (20) @(negedge mclk);
        cmp("idle", 8'h00, {7'h00, conv});
        @(posedge mclk);
        ext_pin <= 1'b1;
        repeat (5) @(posedge mclk);
        ext_pin <= 1'b0;
        wait_until(0, 8'h01, 10);
        wait_until(0, 8'h00, 3000);
        cmp("dma 8", 8'h01, ch_cnt[8]);
        rd(8'hB5, 8'h0C);
        rd(8'hB4, 8'h83);
        // Timer source, differential pairs
        wr(8'hB5, 8'h19);
        clr_cnt();
        wr(8'hB4, 8'h23);
        tmr_evt <= 1'b1;
        @(posedge mclk);
        tmr_evt <= 1'b0;
        wait_until(0, 8'h01, 10);
        wait_until(0, 8'h00, 3000);
        cmp("pairs", 8'h02, ch_cnt[8]);
        rd(8'hB5, 8'h1A);
        rd(8'hBA, 8'h80);
        // Extra queued behind a sequence, negative full scale
        mod_level <= 1'b0;
        wr(8'hB5, 8'h01);
        clr_cnt();
        wr(8'hB4, 8'h73);
        wait_until(0, 8'h01, 10);
        wr(8'hB6, 8'h08);
        wait_until(1, 8'h01, 3000);
        wait_until(0, 8'h00, 20);
        cmp("all", 8'h02, all_cnt);
        rd(8'hB5, 8'h08);
        rd(8'hB4, 8'hB3);
        rd(8'hBA, 8'h00);
        rd(8'hBB, 8'h80);
        // Extra while idle, slowest rate, differential reference
        mod_level <= 1'b1;
        wr(8'hB6, 8'hFD);
        repeat (3) @(negedge mclk);
        cmp("busy", 8'h01, {7'h00, conv});
        cmp("cfg", 8'hFD, mux_cfg);
        @(posedge mclk);
        wait_until(1, 8'h02, 4000);
        rd(8'hBA, 8'hF0);
        rd(8'hBB, 8'h7F);
        rd(8'hB5, 8'h0D);
        cmp("all", 8'h02, all_cnt);
        // Free run restarts after each sequence
        wr(8'hB5, 8'h2C);
        clr_cnt();
        wr(8'hB4, 8'h13);
        wait_until(2, 8'h02, 3500);
        wr(8'hB4, 8'h33);
        wait_until(0, 8'h00, 1800);
        cmp("irq", 8'h00, irq_cnt);
        rd(8'hBA, 8'hC0);
        stop_test();
    end
endmodule // test_adc_sequencer_control
